// >>> gauge_pm_pkg.sv
// Constants shared by the power-mode and charge-status sequencer.
package gauge_pm_pkg;
	// Clock and time figures, each in its own unit.
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned ONE_SEC_NS         = 1000000000;
	localparam int unsigned STRETCH_MAX_NS     = 4000000;
	localparam int unsigned SEC_CYCLES_DEF     = ONE_SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned STRETCH_CYCLES_DEF = STRETCH_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned TAPER_WIN_SEC_DEF  = 40;
	localparam logic [7:0]  CAL_CYCLES         = 8'h10;
	localparam logic [4:0]  NORMAL_INTERVAL_S  = 5'h01;
	localparam logic [4:0]  SLEEP_INTERVAL_S   = 5'h14;
	localparam logic [1:0]  TAPER_WINDOWS      = 2'h2;
	localparam logic [7:0]  DS_WAIT_MIN        = 8'h01;
	localparam logic [7:0]  DS_WAIT_MAX        = 8'hF0;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_TAPER    = 8'h04;
	localparam logic [7:0] REG_CHG_TGT  = 8'h08;
	localparam logic [7:0] REG_TEMP_LIM = 8'h0C;
	localparam logic [7:0] REG_THRESH   = 8'h10;
	localparam logic [7:0] REG_DS_WAIT  = 8'h14;
	localparam logic [7:0] REG_REQ_CHG  = 8'h18;
	localparam logic [7:0] REG_STATUS   = 8'h1C;
	// Field positions.
	localparam int unsigned CTRL_SLEEP_EN_BIT = 0;
	localparam int unsigned CTRL_DS_CMD_BIT   = 1;
	// Reset values.
	localparam logic        RST_SLEEP_EN   = 1'b1;
	localparam logic [15:0] RST_TAPER_CUR  = 16'h0064;
	localparam logic [15:0] RST_TAPER_MARG = 16'h0064;
	localparam logic [15:0] RST_CHG_TGT    = 16'h1068;
	localparam logic [15:0] RST_TEMP_LO    = 16'h0000;
	localparam logic [15:0] RST_TEMP_HI    = 16'h01C2;
	localparam logic [15:0] RST_TEMP_HYS   = 16'h0032;
	localparam logic [15:0] RST_SLEEP_CUR  = 16'h000A;
	localparam logic [7:0]  RST_DS_WAIT    = 8'h0F;
	// Power mode codes as seen on the mode output.
	localparam logic [1:0] MODE_FULL     = 2'h0;
	localparam logic [1:0] MODE_REDUCED  = 2'h1;
	localparam logic [1:0] MODE_DEEP     = 2'h2;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h3;
	// Battery activity codes on the charge state input.
	localparam logic [1:0] CHG_RELAX     = 2'h0;
	localparam logic [1:0] CHG_DISCHARGE = 2'h1;
	localparam logic [1:0] CHG_CHARGE    = 2'h2;
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_CAL,
		ST_SLEEP,
		ST_DEEP,
		ST_SHUTDOWN
	} pm_state_e;
endpackage

// >>> gauge_power_mode_charge_status.sv
// Power-mode sequencer with charge termination and charge-inhibit status, AHB-Lite registers.
module gauge_power_mode_charge_status
	import gauge_pm_pkg::*;
#(
	parameter int unsigned SEC_CYCLES     = gauge_pm_pkg::SEC_CYCLES_DEF,
	parameter int unsigned STRETCH_CYCLES = gauge_pm_pkg::STRETCH_CYCLES_DEF,
	parameter int unsigned TAPER_WIN_SEC  = gauge_pm_pkg::TAPER_WIN_SEC_DEF
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Measurements from the converter, same clock.
	input  wire logic [15:0] averaged_current_value,
	input  wire logic [15:0] cell_voltage,
	input  wire logic [15:0] temperature,
	input  wire logic [1:0]  charge_state,
	// Asynchronous condition inputs.
	input  wire logic        wake_current_threshold,
	input  wire logic        low_battery_condition,
	input  wire logic        system_power_down,
	// Two-wire link, clock line stretchable.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             scl_oe,
	// Status and control outputs.
	output logic      [1:0]  power_mode,
	output logic             hf_osc_en,
	output logic             offset_cal,
	output logic             measure_strobe,
	output logic             full_charge,
	output logic             charge_inhibit_indication,
	output logic             charge_switch_en
);
	import gauge_pm_pkg::*;

	pm_state_e   state_r;
	logic [4:0]  sync1_r;
	logic [4:0]  sync2_r;
	logic [1:0]  link_prev_r;
	logic        wake_s;
	logic        lowbat_s;
	logic        pdown_s;
	logic        scl_s;
	logic        sda_s;
	logic        bus_activity;
	logic        addr_vld_r;
	logic        addr_wr_r;
	logic [7:0]  addr_r;
	logic        wr_en;
	logic        sleep_en_r;
	logic        ds_cmd;
	logic [15:0] taper_cur_r;
	logic [15:0] taper_marg_r;
	logic [15:0] chg_tgt_r;
	logic [15:0] temp_lo_r;
	logic [15:0] temp_hi_r;
	logic [15:0] temp_hys_r;
	logic [15:0] sleep_cur_r;
	logic [7:0]  ds_wait_r;
	logic [7:0]  ds_wait_nxt;
	logic [15:0] req_cur_r;
	logic [15:0] req_volt_r;
	logic [31:0] sec_cnt_r;
	logic        sec_tick;
	logic [4:0]  meas_cnt_r;
	logic [4:0]  meas_interval;
	logic [7:0]  cal_cnt_r;
	logic [15:0] cur_mag;
	logic        low_load;
	logic        ds_flag_r;
	logic [7:0]  ds_count_r;
	logic        ds_enter;
	logic        clear_event;
	logic [31:0] stretch_cnt_r;
	logic [31:0] taper_sec_r;
	logic        taper_ok_r;
	logic [1:0]  taper_wins_r;
	logic        taper_met;
	logic        inhibit_out;
	logic        inhibit_in;
	logic        inhibit_state_r;
	logic        inhibit_enter;

	// Every asynchronous level passes two flops; only the second stage is read.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= 5'h18;
			sync2_r <= 5'h18;
		end else begin
			sync1_r <= {scl_in, sda_in, system_power_down, low_battery_condition, wake_current_threshold};
			sync2_r <= sync1_r;
		end
	end
	assign wake_s   = sync2_r[0];
	assign lowbat_s = sync2_r[1];
	assign pdown_s  = sync2_r[2];
	assign sda_s    = sync2_r[3];
	assign scl_s    = sync2_r[4];

	// Falling edges on either line count as traffic; our own stretch is masked out.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_prev_r <= 2'h3;
		end else begin
			link_prev_r <= {scl_s, sda_s};
		end
	end
	assign bus_activity = ((link_prev_r[1] && !scl_s) || (link_prev_r[0] && !sda_s)) && !scl_oe;

	// Bus address phase capture; the slave never inserts wait states.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_vld_r <= 1'b0;
			addr_wr_r  <= 1'b0;
			addr_r     <= 8'h00;
			hreadyout  <= 1'b0;
			hresp      <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				addr_vld_r <= hsel && htrans[1];
				addr_wr_r  <= hwrite;
				addr_r     <= {haddr[7:2], 2'h0};
			end
		end
	end
	assign wr_en  = addr_vld_r && addr_wr_r;
	assign ds_cmd = wr_en && (addr_r == REG_CTRL) && hwdata[CTRL_DS_CMD_BIT];

	// Out-of-range wait times are pulled into the legal span; zero stays as the disable value.
	always_comb begin
		ds_wait_nxt = hwdata[7:0];
		if (hwdata[7:0] > DS_WAIT_MAX) begin
			ds_wait_nxt = DS_WAIT_MAX;
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_en_r   <= RST_SLEEP_EN;
			taper_cur_r  <= RST_TAPER_CUR;
			taper_marg_r <= RST_TAPER_MARG;
			chg_tgt_r    <= RST_CHG_TGT;
			temp_lo_r    <= RST_TEMP_LO;
			temp_hi_r    <= RST_TEMP_HI;
			temp_hys_r   <= RST_TEMP_HYS;
			sleep_cur_r  <= RST_SLEEP_CUR;
			ds_wait_r    <= RST_DS_WAIT;
		end else if (wr_en) begin
			case (addr_r)
				REG_CTRL: begin
					sleep_en_r <= hwdata[CTRL_SLEEP_EN_BIT];
				end
				REG_TAPER: begin
					taper_cur_r  <= hwdata[15:0];
					taper_marg_r <= hwdata[31:16];
				end
				REG_CHG_TGT: begin
					chg_tgt_r <= hwdata[15:0];
				end
				REG_TEMP_LIM: begin
					temp_lo_r <= hwdata[15:0];
					temp_hi_r <= hwdata[31:16];
				end
				REG_THRESH: begin
					temp_hys_r  <= hwdata[15:0];
					sleep_cur_r <= hwdata[31:16];
				end
				REG_DS_WAIT: begin
					ds_wait_r <= ds_wait_nxt;
				end
				default: begin
				end
			endcase
		end
	end

	// Requested charge values; the forced zero on inhibit entry beats a software write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_cur_r  <= 16'h0000;
			req_volt_r <= 16'h0000;
		end else if (inhibit_enter) begin
			req_cur_r  <= 16'h0000;
			req_volt_r <= 16'h0000;
		end else if (wr_en && (addr_r == REG_REQ_CHG)) begin
			req_cur_r  <= hwdata[15:0];
			req_volt_r <= hwdata[31:16];
		end
	end

	// Read data is prepared during the address phase so it stands from a flop in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case ({haddr[7:2], 2'h0})
				REG_CTRL:     hrdata <= {31'h0000_0000, sleep_en_r};
				REG_TAPER:    hrdata <= {taper_marg_r, taper_cur_r};
				REG_CHG_TGT:  hrdata <= {16'h0000, chg_tgt_r};
				REG_TEMP_LIM: hrdata <= {temp_hi_r, temp_lo_r};
				REG_THRESH:   hrdata <= {sleep_cur_r, temp_hys_r};
				REG_DS_WAIT:  hrdata <= {24'h00_0000, ds_wait_r};
				REG_REQ_CHG:  hrdata <= {req_volt_r, req_cur_r};
				REG_STATUS:   hrdata <= {16'h0000, ds_count_r, scl_oe, hf_osc_en, inhibit_state_r, ds_flag_r,
					charge_inhibit_indication, full_charge, power_mode};
				default:      hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// One-second time base shared by measurements, countdown and taper windows.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt_r <= 32'h0000_0000;
		end else if (sec_tick) begin
			sec_cnt_r <= 32'h0000_0000;
		end else begin
			sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
		end
	end
	assign sec_tick = (sec_cnt_r == SEC_CYCLES - 1);

	// Measurement cadence: every second in full mode, every twenty in the sleep modes.
	assign meas_interval = (state_r == ST_NORMAL) ? NORMAL_INTERVAL_S : SLEEP_INTERVAL_S;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_cnt_r     <= 5'h00;
			measure_strobe <= 1'b0;
		end else begin
			measure_strobe <= 1'b0;
			if (state_r == ST_SHUTDOWN || state_r == ST_CAL) begin
				meas_cnt_r <= 5'h00;
			end else if (sec_tick) begin
				if (meas_cnt_r + 5'h01 >= meas_interval) begin
					meas_cnt_r     <= 5'h00;
					measure_strobe <= 1'b1;
				end else begin
					meas_cnt_r <= meas_cnt_r + 5'h01;
				end
			end
		end
	end

	// Load magnitude, so a small charge or discharge both count as low load.
	assign cur_mag  = averaged_current_value[15] ? 16'(-averaged_current_value) : averaged_current_value;
	assign low_load = sleep_en_r && (cur_mag < sleep_cur_r);

	// Deep-sleep entry waits for the countdown only when a wait time is programmed.
	assign ds_enter    = ds_flag_r && ((ds_wait_r == 8'h00) || (ds_count_r == 8'h00));
	assign clear_event = bus_activity && (state_r == ST_DEEP);

	// Power-mode sequencer; shutdown is terminal until reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r   <= ST_NORMAL;
			cal_cnt_r <= 8'h00;
		end else begin
			case (state_r)
				ST_NORMAL: begin
					cal_cnt_r <= 8'h00;
					if (lowbat_s || pdown_s) begin
						state_r <= ST_SHUTDOWN;
					end else if (low_load && !wake_s) begin
						state_r <= ST_CAL;
					end
				end
				ST_CAL: begin
					cal_cnt_r <= cal_cnt_r + 8'h01;
					if (lowbat_s || pdown_s) begin
						state_r <= ST_SHUTDOWN;
					end else if (!low_load || wake_s) begin
						state_r <= ST_NORMAL;
					end else if (cal_cnt_r == CAL_CYCLES - 8'h01) begin
						state_r <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (lowbat_s || pdown_s) begin
						state_r <= ST_SHUTDOWN;
					end else if (!low_load || wake_s) begin
						state_r <= ST_NORMAL;
					end else if (ds_enter) begin
						state_r <= ST_DEEP;
					end
				end
				ST_DEEP: begin
					if (lowbat_s || pdown_s) begin
						state_r <= ST_SHUTDOWN;
					end else if (!low_load || wake_s) begin
						state_r <= ST_NORMAL;
					end else if (bus_activity) begin
						state_r <= ST_SLEEP;
					end
				end
				ST_SHUTDOWN: begin
					state_r <= ST_SHUTDOWN;
				end
				default: begin
					state_r <= ST_NORMAL;
				end
			endcase
		end
	end

	// Mode outputs; the fast oscillator stops only in deep sleep and shutdown.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_mode <= MODE_FULL;
			hf_osc_en  <= 1'b1;
			offset_cal <= 1'b0;
		end else begin
			offset_cal <= (state_r == ST_CAL);
			hf_osc_en  <= !(state_r == ST_DEEP || state_r == ST_SHUTDOWN);
			case (state_r)
				ST_SLEEP:    power_mode <= MODE_REDUCED;
				ST_DEEP:     power_mode <= MODE_DEEP;
				ST_SHUTDOWN: power_mode <= MODE_SHUTDOWN;
				default:     power_mode <= MODE_FULL;
			endcase
		end
	end

	// Deep-sleep flag and countdown; a command or expiry that meets a clear in the same cycle wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ds_flag_r  <= 1'b0;
			ds_count_r <= 8'h00;
		end else begin
			if (state_r == ST_CAL || clear_event) begin
				ds_count_r <= ds_wait_r;
			end else if (state_r == ST_SLEEP && sec_tick && ds_wait_r != 8'h00 && ds_count_r != 8'h00) begin
				ds_count_r <= ds_count_r - 8'h01;
			end
			if (ds_cmd) begin
				ds_flag_r <= 1'b1;
			end else if (state_r == ST_SLEEP && sec_tick && ds_wait_r != 8'h00 && ds_count_r == 8'h01) begin
				ds_flag_r <= 1'b1;
			end else if (clear_event && ds_wait_r == 8'h00) begin
				ds_flag_r <= 1'b0;
			end
		end
	end

	// Clock stretch: hold the clock line low for a bounded time so the halted core catches up.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stretch_cnt_r <= 32'h0000_0000;
			scl_oe        <= 1'b0;
			scl_out       <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			if (scl_oe) begin
				if (stretch_cnt_r >= STRETCH_CYCLES - 1) begin
					scl_oe <= 1'b0;
				end
				stretch_cnt_r <= stretch_cnt_r + 32'h0000_0001;
			end else if (bus_activity && (state_r == ST_SLEEP || state_r == ST_DEEP)) begin
				scl_oe        <= 1'b1;
				stretch_cnt_r <= 32'h0000_0000;
			end
		end
	end

	// Taper windows: a window counts only if current stayed below the taper level throughout.
	assign taper_met = (charge_state == CHG_CHARGE) && (taper_wins_r == TAPER_WINDOWS)
		&& ({1'b0, cell_voltage} + {1'b0, taper_marg_r} >= {1'b0, chg_tgt_r});
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			taper_sec_r  <= 32'h0000_0000;
			taper_ok_r   <= 1'b1;
			taper_wins_r <= 2'h0;
		end else if (charge_state != CHG_CHARGE) begin
			taper_sec_r  <= 32'h0000_0000;
			taper_ok_r   <= 1'b1;
			taper_wins_r <= 2'h0;
		end else begin
			if (sec_tick && taper_sec_r >= TAPER_WIN_SEC - 1) begin
				taper_sec_r <= 32'h0000_0000;
				taper_ok_r  <= 1'b1;
				if (!taper_ok_r || cur_mag >= taper_cur_r) begin
					taper_wins_r <= 2'h0;
				end else if (taper_wins_r != TAPER_WINDOWS) begin
					taper_wins_r <= taper_wins_r + 2'h1;
				end
			end else begin
				if (sec_tick) begin
					taper_sec_r <= taper_sec_r + 32'h0000_0001;
				end
				if (cur_mag >= taper_cur_r) begin
					taper_ok_r <= 1'b0;
				end
			end
		end
	end

	// Full-charge flag; set wins, and it drops only once the battery discharges.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_charge <= 1'b0;
		end else if (taper_met) begin
			full_charge <= 1'b1;
		end else if (charge_state == CHG_DISCHARGE) begin
			full_charge <= 1'b0;
		end
	end

	// Temperature windows for the inhibit bit, narrowed by hysteresis on the way back.
	assign inhibit_out = (temperature < temp_lo_r) || (temperature > temp_hi_r);
	assign inhibit_in  = ({1'b0, temperature} >= {1'b0, temp_lo_r} + {1'b0, temp_hys_r})
		&& ({1'b0, temperature} + {1'b0, temp_hys_r} <= {1'b0, temp_hi_r});
	assign inhibit_enter = !inhibit_state_r && inhibit_out && (temperature > temp_lo_r)
		&& (charge_state == CHG_DISCHARGE || charge_state == CHG_RELAX);

	// Inhibit indication and state; charging in progress never opens the charge switch.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_inhibit_indication <= 1'b0;
			inhibit_state_r           <= 1'b0;
			charge_switch_en          <= 1'b1;
		end else begin
			if (inhibit_out) begin
				charge_inhibit_indication <= 1'b1;
			end else if (inhibit_in) begin
				charge_inhibit_indication <= 1'b0;
			end
			if (inhibit_enter) begin
				inhibit_state_r <= 1'b1;
			end else if (inhibit_in) begin
				inhibit_state_r <= 1'b0;
			end
			charge_switch_en <= (charge_state == CHG_CHARGE) || !(inhibit_state_r || inhibit_enter);
		end
	end

endmodule

// >>> gauge_host_link.sv
// Host processor model driving the two-wire link of the sequencer.
module gauge_host_link (
	// Line level as seen after every party's pull.
	input  wire logic scl_line,
	// Frame request from the bench.
	input  wire logic go,
	// Host pulls on the two lines.
	output logic      scl_drv,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	// Lines idle high between frames; the clock stands still there.
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	// One frame of nine clocks, waiting out any stretch before the next.
	always @(posedge go) begin
		sda_drv = 1'b0;
		repeat (9) begin
			#62.5 scl_drv = 1'b0;
			#62.5 scl_drv = 1'b1;
			wait (scl_line === 1'b1);
		end
		#62.5 sda_drv = 1'b1;
	end
endmodule

// >>> gauge_pm_props.sv
// Port checker for the power-mode and charge-status sequencer.
module gauge_pm_props
	import gauge_pm_pkg::*;
#(
	parameter int unsigned STRETCH_CYCLES = 40
) (
	// Clock and reset.
	input wire logic        hclk,
	input wire logic        hresetn,
	// Inputs watched.
	input wire logic [15:0] temperature,
	input wire logic [1:0]  charge_state,
	input wire logic        low_battery_condition,
	// Outputs watched.
	input wire logic        scl_oe,
	input wire logic [1:0]  power_mode,
	input wire logic        hf_osc_en,
	input wire logic        offset_cal,
	input wire logic        charge_inhibit_indication,
	input wire logic        charge_switch_en
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	int unsigned hold_r;
	// Counts stretch length, since a stuck stretch would hang the host.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_r <= 0;
		end else begin
			hold_r <= scl_oe ? hold_r + 1 : 0;
		end
	end
	property p_inh_set;
		temperature > RST_TEMP_HI |-> ##[1:3] charge_inhibit_indication;
	endproperty
	a_inh_set: assert property (p_inh_set) else $error("inhibit not raised");
	property p_inh_clr;
		charge_inhibit_indication && temperature >= RST_TEMP_LO + RST_TEMP_HYS
			&& temperature <= RST_TEMP_HI - RST_TEMP_HYS |-> ##[1:3] !charge_inhibit_indication;
	endproperty
	a_inh_clr: assert property (p_inh_clr) else $error("inhibit not cleared");
	property p_deep_osc;
		power_mode == MODE_DEEP |-> !hf_osc_en;
	endproperty
	a_deep_osc: assert property (p_deep_osc) else $error("oscillator on in deep sleep");
	property p_stretch;
		scl_oe |-> hold_r < STRETCH_CYCLES;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch too long");
	property p_low_bat;
		low_battery_condition |-> ##[1:6] power_mode == MODE_SHUTDOWN;
	endproperty
	a_low_bat: assert property (p_low_bat) else $error("no shutdown on low battery");
	property p_cal_first;
		power_mode == MODE_REDUCED && $past(power_mode) == MODE_FULL |-> $past(offset_cal);
	endproperty
	a_cal_first: assert property (p_cal_first) else $error("reduced mode without calibration");
	property p_chg_sw;
		charge_state == CHG_CHARGE |=> charge_switch_en;
	endproperty
	a_chg_sw: assert property (p_chg_sw) else $error("charge switch off while charging");
	property p_wake_stretch;
		$rose(scl_oe) |-> power_mode == MODE_REDUCED || power_mode == MODE_DEEP;
	endproperty
	a_wake_stretch: assert property (p_wake_stretch) else $error("stretch outside sleep modes");
	c_deep: cover property (power_mode == MODE_DEEP);
	c_stretch: cover property ($rose(scl_oe));
	c_shut: cover property (power_mode == MODE_SHUTDOWN);
endmodule
bind gauge_power_mode_charge_status gauge_pm_props #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_gauge_pm_props (
	.hclk(hclk), .hresetn(hresetn), .temperature(temperature), .charge_state(charge_state),
	.low_battery_condition(low_battery_condition), .scl_oe(scl_oe), .power_mode(power_mode),
	.hf_osc_en(hf_osc_en), .offset_cal(offset_cal),
	.charge_inhibit_indication(charge_inhibit_indication), .charge_switch_en(charge_switch_en));

// >>> gauge_power_mode_charge_status_tb.sv
// Self-checking bench for the power-mode and charge-status sequencer.
module gauge_power_mode_charge_status_tb;
	import gauge_pm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SEC = 100;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [15:0] averaged_current_value = 16'h0020;
	logic [15:0] cell_voltage = 16'h1000;
	logic [15:0] temperature = 16'h0100;
	logic [1:0]  charge_state = CHG_DISCHARGE;
	logic        wake_current_threshold = 1'b0;
	logic        low_battery_condition = 1'b0;
	logic        system_power_down = 1'b0;
	logic        go = 1'b0;
	logic        cal_seen = 1'b0;
	logic [31:0] q;
	int          n;
	int          bad_count = 0;
	int          checked = 0;
	wire logic [31:0] hrdata;
	wire logic [1:0]  power_mode;
	wire logic hready, hreadyout, hresp, scl_in, sda_in, scl_drv, scl_out, scl_oe, hf_osc_en;
	wire logic offset_cal, measure_strobe, full_charge, charge_inhibit_indication, charge_switch_en;
	// Single slave, and a pulled-up clock line low when either party pulls it.
	assign hready = hreadyout;
	assign scl_in = scl_drv & !scl_oe;
	always #5 hclk = ~hclk;
	// Calibration is short, so it is latched for a later look.
	always @(posedge hclk) if (offset_cal === 1'b1) cal_seen <= 1'b1;
	gauge_power_mode_charge_status #(.SEC_CYCLES(SEC), .STRETCH_CYCLES(40), .TAPER_WIN_SEC(2))
		u_gauge_power_mode_charge_status (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .averaged_current_value, .cell_voltage,
		.temperature, .charge_state, .wake_current_threshold, .low_battery_condition,
		.system_power_down, .scl_in, .sda_in, .scl_out, .scl_oe, .power_mode, .hf_osc_en,
		.offset_cal, .measure_strobe, .full_charge, .charge_inhibit_indication, .charge_switch_en);
	gauge_host_link u_gauge_host_link (.scl_line(scl_in), .go, .scl_drv, .sda_drv(sda_in));
	task report_and_stop;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One AHB-Lite single word transfer; the master never assumes the wait count.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task wmode(input logic [1:0] m, input int lim);
		for (int i = 0; i < lim && power_mode !== m; i++) @(posedge hclk);
		chk(power_mode, m);
	endtask
	task settle;
		repeat (6) @(posedge hclk);
	endtask
	// Cycles between two measurement strobes.
	task gap;
		do @(posedge hclk); while (measure_strobe !== 1'b1);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (measure_strobe !== 1'b1 && n < 3000);
	endtask
	task host;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
	endtask
	// A hang ends the run through the same closing task.
	initial begin
		repeat (30000) @(posedge hclk);
		bad_count++;
		report_and_stop;
	end
	// Main sequence: registers, inhibit, taper, then the power modes.
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd(REG_DS_WAIT, 32'h0F);
		rd(REG_CTRL, 32'h1);
		rd(8'h20, 32'h0);
		chk({hreadyout, hresp, scl_out}, 3'b100);
		wr(REG_DS_WAIT, 32'hFF);
		rd(REG_DS_WAIT, 32'hF0);
		wr(REG_REQ_CHG, 32'h10681234);
		temperature <= 16'h01C3;
		settle;
		xfer(1'b0, REG_STATUS, 32'h0, q);
		chk(q[5:3], 3'b101);
		chk(charge_switch_en, 1'b0);
		rd(REG_REQ_CHG, 32'h0);
		temperature <= 16'h01A0;
		settle;
		chk(charge_inhibit_indication, 1'b1);
		temperature <= 16'h0190;
		settle;
		chk(charge_inhibit_indication, 1'b0);
		charge_state <= CHG_CHARGE;
		temperature <= 16'h01C3;
		settle;
		chk(charge_switch_en, 1'b1);
		temperature <= 16'h0100;
		cell_voltage <= 16'h1004;
		n = 0;
		while (full_charge !== 1'b1 && n < 800) begin
			@(posedge hclk);
			n++;
		end
		chk(full_charge, 1'b1);
		// The first window may start part-way through a second, so only three full seconds are certain.
		chk(n >= 3 * SEC - 10, 1'b1);
		gap;
		chk(n, SEC);
		charge_state <= CHG_RELAX;
		wr(REG_DS_WAIT, 32'h0);
		averaged_current_value <= 16'h0005;
		wmode(MODE_REDUCED, 100);
		chk(cal_seen, 1'b1);
		gap;
		chk(n, 20 * SEC);
		wr(REG_CTRL, 32'h3);
		wmode(MODE_DEEP, 10);
		chk(hf_osc_en, 1'b0);
		host;
		wmode(MODE_REDUCED, 30);
		xfer(1'b0, REG_STATUS, 32'h0, q);
		chk(q[4], 1'b0);
		repeat (300) @(posedge hclk);
		chk(power_mode, MODE_REDUCED);
		wake_current_threshold <= 1'b1;
		wmode(MODE_FULL, 10);
		wr(REG_DS_WAIT, 32'h2);
		wake_current_threshold <= 1'b0;
		wmode(MODE_REDUCED, 40);
		repeat (90) @(posedge hclk);
		chk(power_mode, MODE_REDUCED);
		wmode(MODE_DEEP, 160);
		host;
		wmode(MODE_REDUCED, 30);
		repeat (60) @(posedge hclk);
		chk(power_mode, MODE_REDUCED);
		wmode(MODE_DEEP, 260);
		low_battery_condition <= 1'b1;
		wmode(MODE_SHUTDOWN, 10);
		report_and_stop;
	end
endmodule
